//--- hdl/kpio_regport.sv
// serial register port of the keypad expander: target, event FIFO, interrupt pin
// assumes SCL/SDA arrive asynchronously; event source and interrupt sources are local logic
`default_nettype none
module kpio_regport #(
  parameter logic [6:0] TARGET_ADDR = 7'h34,
  parameter int         FIFO_DEPTH  = 16,
  parameter int         NUM_SRC     = 8,
  parameter logic [7:0] ID_VALUE    = 8'h5a  // arbitrary identity value
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  input  wire logic                 SCL_I,
  input  wire logic                 SDA_I,
  output logic                      SDA_O,
  output logic                      SDA_OE,
  input  wire logic                 EVT_VALID,
  input  wire kpio_pkg::kpio_event_t EVT_DATA,
  output logic                      EVT_READY,
  input  wire logic [NUM_SRC-1:0]   INT_SRC,
  output logic                      INT_O,
  output logic                      INT_OE
);
  import kpio_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);

  // refuse settings the logic cannot serve, at elaboration
  if (TARGET_ADDR != KPIO_ADDR_MAIN && TARGET_ADDR != KPIO_ADDR_ALT) begin : g_bad_addr
    $error("target address must be one of the two documented values");
  end
  if (FIFO_DEPTH != 16) begin : g_bad_depth
    $error("event FIFO must be 16 deep to fill its register window");
  end
  if (NUM_SRC < 1 || NUM_SRC > 8) begin : g_bad_src
    $error("interrupt sources must fit one select register");
  end

  // three-stage synchronisers; stage 1 feeds stage 2 only
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  kpio_line_t  line_reg;
  kpio_line_t  line_prev_reg;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
    end
  end

  // a level counts only once stages two and three agree
  wire scl_agree = scl_sync_reg[1] == scl_sync_reg[2];
  wire sda_agree = sda_sync_reg[1] == sda_sync_reg[2];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      line_reg      <= '{scl: 1'b1, sda: 1'b1};
      line_prev_reg <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      if (scl_agree)
        line_reg.scl <= scl_sync_reg[2];
      if (sda_agree)
        line_reg.sda <= sda_sync_reg[2];
      line_prev_reg <= line_reg;
    end
  end

  // bus events; 50 MHz oversampling covers a 1 MHz serial clock (see R12)
  wire scl_rise = line_reg.scl & ~line_prev_reg.scl;
  wire scl_fall = ~line_reg.scl & line_prev_reg.scl;
  wire start_ev = line_reg.scl & line_prev_reg.scl & ~line_reg.sda & line_prev_reg.sda;
  wire stop_ev  = line_reg.scl & line_prev_reg.scl & line_reg.sda & ~line_prev_reg.sda;

  // protocol state
  kpio_state_t state_reg;
  kpio_state_t state_next;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  ptr_reg;
  logic        have_ptr_reg;
  logic        rd_mode_reg;
  logic        host_ack_reg;
  logic        sda_low_reg;
  logic        active_reg;
  logic        bit_seen_reg;

  // register storage and event FIFO
  logic [7:0]  cfg_mem [KPIO_MAP_WORDS];
  kpio_event_t fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] fifo_rd_reg;
  logic [PW-1:0] fifo_wr_reg;
  logic [PW:0]   fifo_cnt_reg;
  logic          ovf_reg;

  // byte-level decode
  wire [7:0] rx_byte   = {shift_reg[6:0], line_reg.sda};
  wire       last_bit  = bit_cnt_reg == 3'h7;
  wire       addr_hit  = shift_reg[7:1] == TARGET_ADDR;  // see R01
  wire       ptr_fifo  = ptr_reg >= KPIO_REG_FIFO_LO && ptr_reg <= KPIO_REG_FIFO_HI;
  wire       ptr_held  = ptr_fifo || ptr_reg == KPIO_REG_STAT;
  wire       ptr_in_map = ptr_reg < 8'(KPIO_MAP_WORDS);
  wire       fifo_empty = fifo_cnt_reg == '0;
  wire       fifo_full  = fifo_cnt_reg == (PW+1)'(FIFO_DEPTH);

  // every FIFO address reads the oldest event (see R18)
  wire [7:0] fifo_head = fifo_empty ? 8'h00 : fifo_mem[fifo_rd_reg];
  wire [7:0] int_view  = 8'({ovf_reg, 2'b00});
  wire [7:0] stat_view = 8'(fifo_cnt_reg);
  wire [7:0] mem_view  = ptr_in_map ? cfg_mem[ptr_reg[5:0]] : 8'h00;
  wire [7:0] rd_data   = ptr_reg == KPIO_REG_ID   ? ID_VALUE  :
                         ptr_reg == KPIO_REG_INT  ? int_view  :
                         ptr_reg == KPIO_REG_STAT ? stat_view :
                         ptr_fifo                 ? fifo_head : mem_view;

  // a byte is handed out at the fall that starts a read byte
  wire load_rd  = scl_fall && ((state_reg == KPIO_ACK_ADR && rd_mode_reg) ||
                               (state_reg == KPIO_RD_ACK && host_ack_reg));
  wire wr_done  = scl_fall && state_reg == KPIO_WR_BYTE && last_bit;
  wire wr_store = wr_done && have_ptr_reg;
  wire pop      = load_rd && ptr_fifo && !fifo_empty;

  // next state on serial clock falls; start and stop override
  always_comb begin
    state_next = state_reg;
    if (start_ev) begin
      state_next = KPIO_ADDR;
    end else if (stop_ev) begin
      state_next = KPIO_IDLE;
    end else if (scl_fall) begin
      unique case (state_reg)
        KPIO_IDLE:    state_next = KPIO_IDLE;
        KPIO_ADDR:    if (last_bit) state_next = addr_hit ? KPIO_ACK_ADR : KPIO_IDLE;  // see R19
        KPIO_ACK_ADR: state_next = rd_mode_reg ? KPIO_RD_BYTE : KPIO_WR_BYTE;
        KPIO_WR_BYTE: if (last_bit) state_next = KPIO_ACK_WR;
        KPIO_ACK_WR:  state_next = KPIO_WR_BYTE;  // see R06
        KPIO_RD_BYTE: if (last_bit) state_next = KPIO_RD_ACK;
        KPIO_RD_ACK:  state_next = host_ack_reg ? KPIO_RD_BYTE : KPIO_IDLE;
        default:      state_next = KPIO_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST)
      state_reg <= KPIO_IDLE;
    else
      state_reg <= state_next;
  end

  // bit counting and shifting; counter restarts at every byte boundary
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
    end else if (start_ev) begin
      bit_cnt_reg <= 3'h0;
    end else if (load_rd) begin
      shift_reg   <= rd_data;
      bit_cnt_reg <= 3'h0;
    end else if (scl_rise && (state_reg == KPIO_ADDR || state_reg == KPIO_WR_BYTE)) begin
      shift_reg <= rx_byte;
    end else if (scl_fall && state_reg == KPIO_RD_BYTE) begin
      shift_reg   <= {shift_reg[6:0], 1'b0};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end else if (scl_fall && (state_reg == KPIO_ADDR || state_reg == KPIO_WR_BYTE)) begin
      bit_cnt_reg <= bit_cnt_reg + 3'(bit_seen_reg);  // see R03
    end else if (scl_fall) begin
      bit_cnt_reg <= 3'h0;
    end
  end

  // the fall that closes a start carries no bit; counting it would ack one bit early
  always_ff @(posedge CLOCK) begin
    if (RST || start_ev)
      bit_seen_reg <= 1'b0;
    else if (scl_rise)
      bit_seen_reg <= 1'b1;
  end

  // direction, pointer and host acknowledge capture
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_mode_reg  <= 1'b0;
      have_ptr_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      ptr_reg      <= 8'h00;
    end else begin
      if (start_ev)
        have_ptr_reg <= 1'b0;  // pointer value itself kept, see R20
      if (scl_fall && state_reg == KPIO_ADDR && last_bit)
        rd_mode_reg <= shift_reg[0];  // see R07
      if (scl_rise && state_reg == KPIO_RD_ACK)
        host_ack_reg <= ~line_reg.sda;  // see R11
      if (wr_done && !have_ptr_reg) begin
        ptr_reg      <= shift_reg;  // see R02
        have_ptr_reg <= 1'b1;
      end else if (wr_store || load_rd) begin
        ptr_reg <= ptr_reg + 8'h01;  // see R05, R10
      end
    end
  end

  // acknowledge and read data drive; changes only while the clock is low
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sda_low_reg <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_low_reg <= 1'b0;
    end else if (load_rd) begin
      sda_low_reg <= ~rd_data[7];  // see R08
    end else if (scl_fall) begin
      unique case (state_reg)
        KPIO_ADDR:    sda_low_reg <= last_bit && addr_hit;  // see R03
        KPIO_WR_BYTE: sda_low_reg <= last_bit;  // see R03, R06
        KPIO_RD_BYTE: sda_low_reg <= !last_bit && !shift_reg[6];
        default:      sda_low_reg <= 1'b0;
      endcase
    end
  end

  assign SDA_O  = 1'b0;
  assign SDA_OE = sda_low_reg;

  // transaction in progress from start to stop
  always_ff @(posedge CLOCK) begin
    if (RST)
      active_reg <= 1'b0;
    else if (start_ev)
      active_reg <= 1'b1;
    else if (stop_ev)
      active_reg <= 1'b0;
  end

  // config stores; read-only low block is not writable (see R04)
  wire cfg_we = wr_store && ptr_in_map && ptr_reg > KPIO_REG_FIFO_HI;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i < KPIO_MAP_WORDS; i++)
        cfg_mem[i] <= KPIO_CFG_RESET;
    end else if (cfg_we) begin
      cfg_mem[ptr_reg[5:0]] <= shift_reg;
    end
  end

  // source waits while the host touches FIFO or counter (see R13, R14)
  wire hold_upd = active_reg && ptr_held;
  assign EVT_READY = !hold_upd;
  wire push      = EVT_VALID && !hold_upd && !fifo_full;
  wire push_drop = EVT_VALID && !hold_upd && fifo_full;
  wire ovf_clr   = wr_store && ptr_reg == KPIO_REG_INT && shift_reg[KPIO_OVF_BIT];

  always_ff @(posedge CLOCK) begin
    if (push)
      fifo_mem[fifo_wr_reg] <= EVT_DATA;
  end

  // FIFO pointers and key event counter; overflow set beats clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fifo_rd_reg  <= '0;
      fifo_wr_reg  <= '0;
      fifo_cnt_reg <= '0;
      ovf_reg      <= 1'b0;
    end else begin
      if (push)
        fifo_wr_reg <= fifo_wr_reg + PW'(1);
      if (pop)
        fifo_rd_reg <= fifo_rd_reg + PW'(1);
      if (push && !pop)
        fifo_cnt_reg <= fifo_cnt_reg + (PW+1)'(1);
      else if (pop && !push)
        fifo_cnt_reg <= fifo_cnt_reg - (PW+1)'(1);
      if (push_drop)
        ovf_reg <= 1'b1;
      else if (ovf_clr)
        ovf_reg <= 1'b0;
    end
  end

  // interrupt pin: selected sources, optional re-pulse when one clears
  function automatic logic [3:0] kpio_ones(input logic [NUM_SRC-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NUM_SRC; i++)
      n = n + 4'(v[i]);
    return n;
  endfunction : kpio_ones

  wire [7:0]         sel_cfg   = cfg_mem[KPIO_REG_SRC_SEL[5:0]];
  wire               repulse   = cfg_mem[KPIO_REG_REPULSE[5:0]][KPIO_REPULSE_BIT];
  wire [NUM_SRC-1:0] enabled   = INT_SRC & sel_cfg[NUM_SRC-1:0];  // see R16
  wire [3:0]         n_now     = kpio_ones(enabled);
  logic [3:0]        n_prev_reg;
  logic [11:0]       gap_cnt_reg;
  wire               one_clear = repulse && n_now != 4'h0 && n_now < n_prev_reg;  // see R17

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      n_prev_reg  <= 4'h0;
      gap_cnt_reg <= 12'h000;
    end else begin
      n_prev_reg <= n_now;
      if (one_clear)
        gap_cnt_reg <= 12'(KPIO_REPULSE_CYC);  // see R17
      else if (gap_cnt_reg != 12'h000)
        gap_cnt_reg <= gap_cnt_reg - 12'h001;
    end
  end

  // open drain: pulled low while any selected source is up, except during a re-pulse gap (see R15)
  assign INT_O  = 1'b0;
  assign INT_OE = n_now != 4'h0 && gap_cnt_reg == 12'h000;
endmodule : kpio_regport
`default_nettype wire

//--- pkg/kpio_pkg.sv
// constants and types shared by the keypad expander register port
// assumes a 50 MHz device clock and an event source on the same clock
// Contract
// R01: answer at address 0x34, variant 0x30
// R02: host opens with start, write address, pointer
// R03: acknowledge address, pointer and written bytes
// R04: single write stores byte at pointer
// R05: burst write advances pointer per byte
// R06: burst write acknowledged until stop
// R07: host reads via repeated start, read bit
// R08: read returns register at written pointer
// R09: host ends single read with nack, stop
// R10: burst read advances pointer per byte
// R11: host acks burst bytes, nacks last
// R12: serial clock up to 1 MHz
// R13: hold FIFO/counter updates during their access
// R14: update delay up to 23 us accepted
// R15: interrupt pin low while enabled source active
// R16: select register gates interrupt sources
// R17: repulse option releases pin 50 us
// R18: any FIFO address reads oldest event
// R19: foreign address ignored, not acknowledged
// R20: pointer survives repeated start
`default_nettype none
package kpio_pkg;
  localparam logic [6:0] KPIO_ADDR_MAIN  = 7'h34;
  localparam logic [6:0] KPIO_ADDR_ALT   = 7'h30;
  localparam logic [7:0] KPIO_REG_ID     = 8'h00;
  localparam logic [7:0] KPIO_REG_INT    = 8'h01;
  localparam logic [7:0] KPIO_REG_STAT   = 8'h02;
  localparam logic [7:0] KPIO_REG_FIFO_LO = 8'h03;
  localparam logic [7:0] KPIO_REG_FIFO_HI = 8'h12;
  localparam logic [7:0] KPIO_REG_REPULSE = 8'h3b;
  localparam logic [7:0] KPIO_REG_SRC_SEL = 8'h3c;
  localparam int         KPIO_MAP_WORDS  = 64;
  localparam int         KPIO_OVF_BIT    = 2;
  localparam int         KPIO_REPULSE_BIT = 0;
  localparam logic [7:0] KPIO_CFG_RESET  = 8'h00;
  localparam int         KPIO_CLK_HZ     = 50_000_000;
  localparam int         KPIO_SCL_MAX_HZ = 1_000_000;
  localparam int         KPIO_REPULSE_US = 50;
  localparam int         KPIO_REPULSE_CYC = KPIO_REPULSE_US * (KPIO_CLK_HZ / 1_000_000);
  localparam int         KPIO_HOLDOFF_US = 23;

  // one recorded event: press/release state and identifier
  typedef struct packed {
    logic       state;
    logic [6:0] ident;
  } kpio_event_t;

  // serial line state after synchronisation
  typedef struct packed {
    logic scl;
    logic sda;
  } kpio_line_t;

  typedef enum logic [2:0] {
    KPIO_IDLE    = 3'b000,
    KPIO_ADDR    = 3'b001,
    KPIO_ACK_ADR = 3'b010,
    KPIO_WR_BYTE = 3'b011,
    KPIO_ACK_WR  = 3'b100,
    KPIO_RD_BYTE = 3'b101,
    KPIO_RD_ACK  = 3'b110
  } kpio_state_t;
endpackage : kpio_pkg
`default_nettype wire

//--- bench/kpio_host.sv
// host controller model for the serial register port: clocks the link, pulls data low
// assumes the bench makes the data wire from both pull-downs with a pull-up
`default_nettype none
module kpio_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 13;  // 13 clocks a quarter bit keeps the link under 1 MHz

  // idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // wait n quarter bits, moving just after an edge
  task automatic q(input int n);
    repeat (n * QTR) @(posedge clk);
    #1;
  endtask : q

  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_pull = 1'b0;
    q(1);
    scl = 1'b1;
    q(1);
    sda_pull = 1'b1;
    q(1);
    scl = 1'b0;
  endtask : start

  // stop: data rises while the clock is high; the clock then stands high
  task automatic stop();
    sda_pull = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    sda_pull = 1'b0;
    q(2);
  endtask : stop

  // one bit: data changes only while the clock is low, sampled mid high phase
  task automatic bit_x(input logic tx, output logic rx);
    q(1);
    sda_pull = ~tx;
    q(1);
    scl = 1'b1;
    q(1);
    rx = sda;
    q(1);
    scl = 1'b0;
  endtask : bit_x

  // eight bits msb first, then the acknowledge slot, pulled low only when mack is set
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(~mack, ack);
  endtask : xfer
endmodule : kpio_host
`default_nettype wire

//--- bench/kpio_regport_asserts.sv
// pin-level assertions for the keypad expander register port
// assumes it is bound to kpio_regport and the host clock stays under 1 MHz
`default_nettype none
module kpio_regport_asserts #(
  parameter int NUM_SRC = 8
) (
  input wire logic                  CLOCK,
  input wire logic                  RST,
  input wire logic                  SCL_I,
  input wire logic                  SDA_I,
  input wire logic                  SDA_O,
  input wire logic                  SDA_OE,
  input wire logic                  EVT_VALID,
  input wire kpio_pkg::kpio_event_t EVT_DATA,
  input wire logic                  EVT_READY,
  input wire logic [NUM_SRC-1:0]    INT_SRC,
  input wire logic                  INT_O,
  input wire logic                  INT_OE
);
  timeunit 1ns;
  timeprecision 1ps;
  import kpio_pkg::*;
  logic [7:0] idle_cnt;  // cycles with both lines high

  // saturating idle counter; a host high phase never reaches 30, so above it the bus is free
  always_ff @(posedge CLOCK) begin
    if (RST || !SCL_I || !SDA_I) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hff) idle_cnt <= idle_cnt + 8'h01;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_open_drain; !SDA_O && !INT_O; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain output level not low");
  property p_oe_scl_low; $changed(SDA_OE) |-> !SCL_I; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed while clock high");
  property p_oe_width; $rose(SDA_OE) |=> SDA_OE [*8]; endproperty
  a_oe_width: assert property (p_oe_width)
    else $error("data drive too short");
  property p_idle_release; idle_cnt > 8'd30 |-> EVT_READY && !SDA_OE; endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("idle bus yet port busy");
  property p_ready_fall; $fell(EVT_READY) |-> idle_cnt < 8'd20; endproperty
  a_ready_fall: assert property (p_ready_fall)
    else $error("event hold without bus access");
  property p_int_cause; INT_OE |-> |INT_SRC; endproperty
  a_int_cause: assert property (p_int_cause)
    else $error("interrupt without source");
  property p_int_rst; $fell(RST) |-> !INT_OE; endproperty
  a_int_rst: assert property (p_int_rst)
    else $error("interrupt after reset");
  property p_int_hold;
    INT_OE && $stable(INT_SRC) ##1 ($stable(INT_SRC) && idle_cnt > 8'd30) |-> INT_OE;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("interrupt released with steady sources");

  c_ack: cover property ($rose(SDA_OE));
  c_hold: cover property ($fell(EVT_READY));
  c_repulse: cover property ($fell(INT_OE) && |INT_SRC);
endmodule : kpio_regport_asserts
`default_nettype wire

//--- bench/kpio_regport_tb.sv
// self-checking bench for the register port, with a host model on the serial link
// assumes kpio_host, the checker and the package are compiled first
`default_nettype none
module kpio_regport_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kpio_pkg::*;
  localparam logic [7:0] ID_TB = 8'ha5;  // arbitrary identity value
  typedef struct packed {logic wr; logic [7:0] ptr; logic [7:0] wd; logic [7:0] exp;} kpio_row_t;
  logic        clock, rst, evt_valid, sda_oe, sda_o, evt_ready, int_o, int_oe, scl, h_pull, ack;
  kpio_event_t evt_data;
  logic [7:0]  int_src, rx;
  logic [7:0]  rd [4];
  int          n_fail = 0;
  int          n_compared = 0;
  wire logic   sda = ~(h_pull | sda_oe);  // pulled-up wire, both ends only pull low
  kpio_row_t   rows [6] = '{'{1'b0, 8'h3b, 8'h00, KPIO_CFG_RESET},
    '{1'b0, 8'h3c, 8'h00, KPIO_CFG_RESET}, '{1'b1, 8'h00, 8'h77, ID_TB},
    '{1'b1, 8'h3f, 8'hc3, 8'hc3}, '{1'b1, 8'h40, 8'h99, 8'h00}, '{1'b0, 8'h02, 8'h00, 8'h00}};

  kpio_regport #(.TARGET_ADDR(KPIO_ADDR_MAIN), .ID_VALUE(ID_TB)) u_dut (
    .CLOCK(clock), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .EVT_VALID(evt_valid), .EVT_DATA(evt_data), .EVT_READY(evt_ready), .INT_SRC(int_src),
    .INT_O(int_o), .INT_OE(int_oe));
  kpio_host u_host (.clk(clock), .sda(sda), .scl(scl), .sda_pull(h_pull));

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // start, write address and pointer, all acknowledged
  task automatic open_ptr(input logic [7:0] ptr);
    u_host.start();
    u_host.xfer({KPIO_ADDR_MAIN, 1'b0}, 1'b0, rx, ack);
    chk1("address ack", 1'b0, ack);
    u_host.xfer(ptr, 1'b0, rx, ack);
    chk1("pointer ack", 1'b0, ack);
  endtask : open_ptr
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d [4], input int n);
    open_ptr(ptr);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(d[i], 1'b0, rx, ack);
      chk1("data ack", 1'b0, ack);
    end
    u_host.stop();
  endtask : reg_wr
  // repeated start keeps the pointer; host acks all but the last byte
  task automatic reg_rd(input logic [7:0] ptr, input int n);
    open_ptr(ptr);
    u_host.start();
    u_host.xfer({KPIO_ADDR_MAIN, 1'b1}, 1'b0, rx, ack);
    chk1("read address ack", 1'b0, ack);
    for (int i = 0; i < n; i++) u_host.xfer(8'hff, i < n - 1, rd[i], ack);
    u_host.stop();
  endtask : reg_rd
  // offer one event and wait, bounded, until it is taken
  task automatic push(input logic [7:0] e);
    evt_valid = 1'b1;
    evt_data = e;
    for (int k = 0; k < 5000 && evt_ready !== 1'b1; k++) tick(1);
    chk1("event taken", 1'b1, evt_ready);
    tick(1);
    evt_valid = 1'b0;
    tick(1);
  endtask : push
  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #1_800_000;
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    evt_valid = 1'b0;
    evt_data = '0;
    int_src = 8'h00;
    tick(4);
    rst = 1'b0;
    tick(4);
    chk1("int pin", 1'b0, int_oe);
    chk1("event ready", 1'b1, evt_ready);
    for (int r = 0; r < 6; r++) begin
      if (rows[r].wr) reg_wr(rows[r].ptr, '{rows[r].wd, 8'h00, 8'h00, 8'h00}, 1);
      reg_rd(rows[r].ptr, 1);
      chk8("register", rows[r].exp, rd[0]);
    end
    $display("test rows done");
    u_host.start();
    u_host.xfer({7'h35, 1'b0}, 1'b0, rx, ack);
    chk1("foreign address nack", 1'b1, ack);
    u_host.stop();
    reg_wr(8'h30, '{8'h11, 8'h22, 8'h33, 8'h44}, 4);
    reg_rd(8'h30, 4);
    for (int i = 0; i < 4; i++) chk8("burst", 8'(8'h11 * (i + 1)), rd[i]);
    $display("test burst done");
    open_ptr(KPIO_REG_FIFO_LO);
    tick(3);
    chk1("event hold", 1'b0, evt_ready);
    u_host.stop();
    tick(10);
    chk1("event release", 1'b1, evt_ready);
    push(8'h83);
    push(8'h05);
    push(8'h8a);
    reg_rd(KPIO_REG_STAT, 1);
    chk8("event count", 8'h03, rd[0]);
    reg_rd(8'h07, 3);
    chk8("event 1", 8'h83, rd[0]);
    chk8("event 2", 8'h05, rd[1]);
    chk8("event 3", 8'h8a, rd[2]);
    $display("test events done");
    reg_wr(KPIO_REG_SRC_SEL, '{8'h03, 8'h00, 8'h00, 8'h00}, 1);
    int_src = 8'h04;
    tick(2);
    chk1("masked source", 1'b0, int_oe);
    int_src = 8'h01;
    tick(2);
    chk1("enabled source", 1'b1, int_oe);
    int_src = 8'h03;
    tick(2);
    int_src = 8'h01;
    tick(2);
    chk1("kept asserted", 1'b1, int_oe);
    reg_wr(KPIO_REG_REPULSE, '{8'h01, 8'h00, 8'h00, 8'h00}, 1);
    int_src = 8'h03;
    tick(2);
    int_src = 8'h01;
    tick(10);
    chk1("repulse gap", 1'b0, int_oe);
    tick(KPIO_REPULSE_CYC - 40);
    chk1("repulse gap end", 1'b0, int_oe);
    tick(60);
    chk1("repulse again", 1'b1, int_oe);
    $display("test interrupt done");
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(4);
    chk1("int pin after reset", 1'b0, int_oe);
    reg_rd(KPIO_REG_SRC_SEL, 1);
    chk8("select after reset", KPIO_CFG_RESET, rd[0]);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : kpio_regport_tb

bind kpio_regport kpio_regport_asserts #(.NUM_SRC(NUM_SRC)) u_chk (
  .CLOCK(CLOCK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .EVT_VALID(EVT_VALID), .EVT_DATA(EVT_DATA), .EVT_READY(EVT_READY), .INT_SRC(INT_SRC),
  .INT_O(INT_O), .INT_OE(INT_OE));
`default_nettype wire
